// ===== logic/hms_pkg.sv
// shared constants of the hall sensor conversion and serial port
package hms_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned EFF_SAMPLE_NS = 47500;
  localparam int unsigned EFF_SAMPLE_CYC = EFF_SAMPLE_NS / CLK_PERIOD_NS;
  localparam int unsigned TRIG_LAT_CYC = 3;
  localparam int unsigned Z_SAMPLE_CYC = EFF_SAMPLE_CYC - TRIG_LAT_CYC;
  localparam int unsigned PAIR_SPACING_NS = 10000;
  localparam int unsigned PAIR_SPACING_CYC = PAIR_SPACING_NS / CLK_PERIOD_NS;
  // register map
  localparam logic [6:0] CFG_ADDR = 7'h02;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam int unsigned CFG_TRIG_BIT = 10;
  // frame-select field is nonzero when 0480h is written; its set bit is bit 7
  localparam int unsigned CFG_FRAME_BIT = 7;
  // serial frame layout
  localparam int unsigned FRAME_BITS = 32;
  localparam int unsigned CMD_READ_BIT = 31;
  localparam int unsigned ADDR_MSB = 30;
  localparam int unsigned ADDR_LSB = 24;
  localparam int unsigned DATA_MSB = 23;
  localparam int unsigned DATA_LSB = 8;
  localparam int unsigned ADC_BITS = 12;
endpackage : hms_pkg

// ===== logic/hms_conv.sv
// paired-axis conversion sequencer: x, then z, then x again, x averaged
`timescale 1ns/1ps
`default_nettype none
module hms_conv #(
  parameter int unsigned ZPOINT = hms_pkg::Z_SAMPLE_CYC,
  parameter int unsigned SPACING = hms_pkg::PAIR_SPACING_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [11:0] adcX,
  input wire logic [11:0] adcZ,
  output logic busy,
  output logic done,
  output logic [11:0] xAvg,
  output logic [11:0] zVal
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_RUN = 3'b010,
    S_DONE = 3'b100
  } hms_conv_state_t;

  localparam logic [11:0] X1_AT = 12'(ZPOINT - SPACING);
  localparam logic [11:0] Z_AT = 12'(ZPOINT);
  localparam logic [11:0] X2_AT = 12'(ZPOINT + SPACING);

  hms_conv_state_t state;
  logic [11:0] count;
  logic [11:0] xFirst;
  logic [12:0] xSum;
  logic zTake;
  logic [11:0] sinceStart;

  assign busy = (state != S_IDLE);
  assign done = (state == S_DONE);
  assign zTake = (state == S_RUN) && (count == Z_AT);
  assign xSum = {xFirst[11], xFirst} + {adcX[11], adcX};

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= S_IDLE;
    end else begin
      unique case (state)
        S_IDLE: if (start) state <= S_RUN;
        S_RUN: if (count == X2_AT) state <= S_DONE;
        S_DONE: state <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || state != S_RUN) begin
      count <= 12'h000;
    end else begin
      count <= count + 12'h001;
    end
  end

  // x at both ends, z in the middle: averaged x shares z's instant
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      xFirst <= 12'h000;
      xAvg <= 12'h000;
      zVal <= 12'h000;
    end else if (state == S_RUN) begin
      if (count == X1_AT) xFirst <= adcX;
      if (zTake) zVal <= adcZ;
      if (count == X2_AT) xAvg <= xSum[12:1];
    end
  end

  // helper for checks only
  always_ff @(posedge clock) begin
    if (!rst_n || start) begin
      sinceStart <= 12'h000;
    end else if (sinceStart != 12'hFFF) begin
      sinceStart <= sinceStart + 12'h001;
    end
  end

  a_z_instant: assert property (@(posedge clock) disable iff (!rst_n)
    zTake |-> sinceStart == Z_AT)
    else $error("z sample not at effective instant");
  a_x_average: assert property (@(posedge clock) disable iff (!rst_n)
    (state == S_RUN && count == X2_AT) |=> done && xAvg == 12'(($signed({$past(xFirst[11]), $past(xFirst)})
      + $signed({$past(adcX[11]), $past(adcX)})) >>> 1))
    else $error("x average wrong");
  a_seq_length: assert property (@(posedge clock) disable iff (!rst_n)
    done |-> sinceStart == X2_AT + 12'h001)
    else $error("sequence length wrong");
endmodule : hms_conv
`default_nettype wire

// ===== logic/hms_hall_sensor.sv
// hall sensor core: triggered paired-axis conversion and serial register port
// How it works
// - trigger falling edge starts a conversion
// - sample x, z, x; average both x
// - all sensors start together on shared trigger
// - effective sample about 47.5 us after trigger
// - special frame: two 12-bit channels, kept
`timescale 1ns/1ps
`default_nettype none
module hms_hall_sensor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic conversionTriggerN,
  input wire logic [11:0] adcX,
  input wire logic [11:0] adcZ,
  input wire logic sclk,
  input wire logic sensorSelectN,
  input wire logic sdi,
  output logic sdo,
  output logic sdoOeN
);
  // ---------------- core clock domain ----------------
  logic [2:0] trigSync;
  logic [2:0] csSync;
  logic trigFall;
  logic csRise;
  logic csIdle;
  logic start;
  logic convBusy;
  logic convDone;
  logic [11:0] convX;
  logic [11:0] convZ;
  logic [15:0] cfgWord;
  logic [6:0] lastAddr;
  logic [2:0] setCount;
  logic [11:0] pubX;
  logic [11:0] pubZ;
  logic [3:0] pubStatus;
  logic [15:0] pubRead;
  logic pubSpecial;
  logic cfgWrite;
  // ---------------- serial clock domain ----------------
  logic [5:0] inCount;
  logic [31:0] rxShift;
  logic frameDone;
  logic [4:0] outPtr;
  logic [31:0] txFrame;

  function automatic logic [15:0] regRead(input logic [6:0] addr, input logic [15:0] cfg);
    regRead = (addr == hms_pkg::CFG_ADDR) ? cfg : 16'h0000;
  endfunction : regRead

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      trigSync <= 3'h7;
      csSync <= 3'h7;
    end else begin
      trigSync <= {trigSync[1:0], conversionTriggerN};
      csSync <= {csSync[1:0], sensorSelectN};
    end
  end

  assign trigFall = trigSync[2] && !trigSync[1];
  assign csRise = !csSync[2] && csSync[1];
  assign csIdle = csSync[2] && csSync[1];
  // every sensor sees the same trigger pin, so their starts line up
  assign start = trigFall && cfgWord[hms_pkg::CFG_TRIG_BIT] && !convBusy;

  hms_conv u_conv (
    .clock(clock),
    .rst_n(rst_n),
    .start(start),
    .adcX(adcX),
    .adcZ(adcZ),
    .busy(convBusy),
    .done(convDone),
    .xAvg(convX),
    .zVal(convZ)
  );

  // frame fields stay still while select is high
  assign cfgWrite = csRise && frameDone && !rxShift[hms_pkg::CMD_READ_BIT]
    && rxShift[hms_pkg::ADDR_MSB:hms_pkg::ADDR_LSB] == hms_pkg::CFG_ADDR;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfgWord <= hms_pkg::CFG_RESET;
    end else if (cfgWrite) begin
      cfgWord <= rxShift[hms_pkg::DATA_MSB:hms_pkg::DATA_LSB];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lastAddr <= 7'h00;
    end else if (csRise && frameDone) begin
      lastAddr <= rxShift[hms_pkg::ADDR_MSB:hms_pkg::ADDR_LSB];
    end
  end

  // rolling count of finished conversion sets
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      setCount <= 3'h0;
    end else if (convDone) begin
      setCount <= setCount + 3'h1;
    end
  end

  // snapshot for the serial side, only refreshed while deselected
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pubX <= 12'h000;
      pubZ <= 12'h000;
      pubStatus <= 4'h0;
      pubRead <= 16'h0000;
      pubSpecial <= 1'b0;
    end else if (csIdle) begin
      pubX <= convX;
      pubZ <= convZ;
      pubStatus <= {convBusy, setCount};
      pubRead <= regRead(lastAddr, cfgWord);
      pubSpecial <= cfgWord[hms_pkg::CFG_FRAME_BIT];
    end
  end

  a_trig_start: assert property (@(posedge clock) disable iff (!rst_n)
    (trigSync[2] && !trigSync[1] && cfgWord[hms_pkg::CFG_TRIG_BIT] && !convBusy) |=> convBusy)
    else $error("trigger edge did not start conversion");
  a_trig_ignored: assert property (@(posedge clock) disable iff (!rst_n)
    (!convBusy && !cfgWord[hms_pkg::CFG_TRIG_BIT]) |=> !convBusy)
    else $error("conversion started without trigger mode");
  a_frame_kept: assert property (@(posedge clock) disable iff (!rst_n)
    (!cfgWrite && csIdle) |=> pubSpecial == $past(cfgWord[hms_pkg::CFG_FRAME_BIT]) && $stable(cfgWord))
    else $error("frame select changed without a write");
  a_cfg_write: assert property (@(posedge clock) disable iff (!rst_n)
    cfgWrite |=> cfgWord == $past(rxShift[hms_pkg::DATA_MSB:hms_pkg::DATA_LSB]))
    else $error("register write lost");

  // ---------------- serial side, mode 0 ----------------
  always_ff @(posedge sclk or posedge sensorSelectN) begin
    if (sensorSelectN) begin
      inCount <= 6'h00;
    end else if (inCount != 6'(hms_pkg::FRAME_BITS)) begin
      inCount <= inCount + 6'h01;
    end
  end

  always_ff @(posedge sclk) begin
    if (inCount != 6'(hms_pkg::FRAME_BITS)) begin
      rxShift <= {rxShift[30:0], sdi};
    end
  end

  always_ff @(posedge sclk) begin
    if (inCount == 6'h00) begin
      frameDone <= 1'b0;
    end else if (inCount == 6'(hms_pkg::FRAME_BITS - 1)) begin
      frameDone <= 1'b1;
    end
  end

  always_ff @(negedge sclk or posedge sensorSelectN) begin
    if (sensorSelectN) begin
      outPtr <= 5'h00;
    end else begin
      outPtr <= outPtr + 5'h01;
    end
  end

  // special frame carries both channels every access until cleared
  always_comb begin
    if (pubSpecial) begin
      txFrame = {pubX, pubZ, pubStatus, 4'h0};
    end else begin
      txFrame = {pubRead, 8'h00, pubStatus, 4'h0};
    end
  end

  assign sdo = txFrame[~outPtr];
  assign sdoOeN = sensorSelectN;

  a_special_msb: assert property (@(posedge sclk) disable iff (sensorSelectN)
    (pubSpecial && outPtr == 5'h0C) |-> sdo == pubZ[11])
    else $error("special frame z channel misplaced");
endmodule : hms_hall_sensor
`default_nettype wire

// ===== verification/hms_host_model.sv
// host side: serial master and shared trigger source
`timescale 1ns/1ps
`default_nettype none
module hms_host_model (
  output logic sclk,
  output logic sensorSelectN,
  output logic sdi,
  output logic conversionTriggerN,
  input wire logic sdo
);
  initial begin
    sclk = 1'b0;
    sensorSelectN = 1'b1;
    sdi = 1'b0;
    conversionTriggerN = 1'b1;
  end

  task automatic trig();
    conversionTriggerN = 1'b0;
    #100;
    conversionTriggerN = 1'b1;
  endtask : trig

  // n below 32 gives a short frame
  task automatic frame(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    sensorSelectN = 1'b0;
    sdi = tx[31];
    #200;
    for (int k = 0; k < n; k++) begin
      #3 sclk = 1'b1;
      rx = {rx[30:0], sdo};
      #3 sclk = 1'b0;
      if (k < 31) sdi = tx[30 - k];
      if (k == 15) #30;
    end
    #3 sensorSelectN = 1'b1;
    sdi = ~sdi;
    #300;
  endtask : frame
endmodule : hms_host_model
`default_nettype wire

// ===== verification/quad_hall_linear_position_tb_top.sv
// bench for the hall sensor core: register frames and triggered conversions
`timescale 1ns/1ps
`default_nettype none
module quad_hall_linear_position_tb_top;
  logic clock;
  logic rst_n;
  logic [11:0] adcX;
  logic [11:0] adcZ;
  logic [31:0] rx;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  wire logic sclk;
  wire logic sensorSelectN;
  wire logic sdi;
  wire logic sdo;
  wire logic sdoOeN;
  wire logic conversionTriggerN;

  hms_hall_sensor uut (
    .clock(clock),
    .rst_n(rst_n),
    .conversionTriggerN(conversionTriggerN),
    .adcX(adcX),
    .adcZ(adcZ),
    .sclk(sclk),
    .sensorSelectN(sensorSelectN),
    .sdi(sdi),
    .sdo(sdo),
    .sdoOeN(sdoOeN)
  );

  hms_host_model host (
    .sclk(sclk),
    .sensorSelectN(sensorSelectN),
    .sdi(sdi),
    .conversionTriggerN(conversionTriggerN),
    .sdo(sdo)
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic end_of_test();
    if (fails == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // x changes between the two x samples, z changes after its sample
  task automatic conv(input logic [11:0] x1, input logic [11:0] x2, input logic [11:0] z, input logic [2:0] n);
    logic [12:0] s;
    s = {x1[11], x1} + {x2[11], x2};
    adcX = x1;
    adcZ = z;
    host.trig();
    repeat (500) @(negedge clock);
    host.frame(32, 32'h8200_0000, rx);
    chk("busy", rx[7:4], {1'b1, n - 3'h1});
    host.trig();
    repeat (680) @(negedge clock);
    adcX = x2;
    adcZ = ~z;
    repeat (1400) @(negedge clock);
    host.frame(32, 32'h8200_0000, rx);
    chk("pair", rx, {s[12:1], z, 1'b0, n, 4'h0});
  endtask : conv

  always @(posedge clock) begin
    cycles++;
    if (cycles == 15000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    rst_n = 1'b0;
    adcX = 12'h064;
    adcZ = 12'h3E8;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    chk("oe idle", sdoOeN, 32'h1);
    host.trig();
    repeat (1600) @(negedge clock);
    host.frame(32, 32'h8500_0000, rx);
    host.frame(32, 32'h8200_0000, rx);
    chk("unmapped", rx[31:16], 32'h0);
    host.frame(32, 32'h0204_0000, rx);
    chk("cfg reset", rx[31:16], 32'h0);
    chk("no conversion", rx[7:0], 32'h0);
    host.frame(32, 32'h8200_0000, rx);
    chk("cfg", rx[31:16], 32'h0400);
    host.frame(16, 32'h0200_0000, rx);
    host.frame(32, 32'h8200_0000, rx);
    chk("short", rx[31:16], 32'h0400);
    host.frame(32, 32'h0204_8000, rx);
    conv(12'h064, 12'h12C, 12'h3E8, 3'h1);
    conv(12'hFCE, 12'hF6A, 12'h800, 3'h2);
    conv(12'h7FF, 12'h7FF, 12'h001, 3'h3);
    host.frame(32, 32'h0204_8000, rx);
    chk("kept", rx, 32'h7FF0_0130);
    end_of_test();
  end
endmodule : quad_hall_linear_position_tb_top
`default_nettype wire
